// ---- rtl/wks_pkg.sv ----
// shared constants of the wake signalling block
package wks_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00; // wake signalling configuration byte, read only
  localparam logic [7:0] OFS_FCFG = 8'h04; // wake filter 0 configuration word, read only
  localparam logic [7:0] OFS_MASK0 = 8'h08; // first of four wake filter 0 byte mask words
  localparam logic [7:0] OFS_MASK3 = 8'h14; // last byte mask word
  localparam logic [7:0] OFS_STAT = 8'h18; // sticky event status, read only
  localparam logic [7:0] OFS_CLR = 8'h1c; // write one to clear status, write only
  localparam logic [7:0] OFS_IEN = 8'h20; // interrupt enable, read/write

  // configuration byte field positions
  localparam int BIT_SIG_EN = 7; // wake_signaling_enable
  localparam int BIT_STYLE = 6; // wake_indication_style, 1 = pulse
  localparam int BIT_DUR = 5; // wake_pulse_duration_select, 1 = long
  localparam int BIT_POL = 4; // wake_active_polarity, 1 = high
  localparam int BIT_DRV = 3; // wake_pin_driver_style, 1 = push-pull
  localparam int BIT_LINK_EN = 2; // phy link change source enable
  localparam int BIT_PKT_EN = 1; // packet detection source enable
  localparam int BIT_DA_EN = 0; // exact destination address source enable

  // status / enable / clear bit positions
  localparam int ST_PIN = 0; // wake input pin seen high
  localparam int ST_PKT = 1; // packet detected
  localparam int ST_WFF = 2; // wake frame filter match
  localparam int ST_DA = 3; // exact destination address match
  localparam int ST_LINK = 4; // phy link change
  localparam int ST_LOADED = 5; // wake filter 0 block fully loaded
  localparam int ST_W = 6; // width of status, clear and enable registers

  // reset values
  localparam logic [7:0] CFG_RST = 8'h00; // signalling off until loaded
  localparam logic [ST_W-1:0] IEN_RST = 6'h00; // all interrupts masked

  // wake filter 0 block layout in bytes
  localparam int WFF_CFG_BYTES = 4; // configuration word bytes
  localparam int WFF_MASK_BYTES = 16; // byte mask bytes
  localparam int WFF_LEN = WFF_CFG_BYTES + WFF_MASK_BYTES; // whole block, 20 bytes

  // pulse timing
  localparam int CLK_KHZ = 50000; // core clock rate
  localparam int PULSE_SHORT_US = 1500; // short pulse, 1.5 ms
  localparam int PULSE_LONG_US = 150000; // long pulse, 150 ms
  // cycles per microsecond first, so the product stays inside 32 bits
  localparam int PULSE_SHORT_CYC = PULSE_SHORT_US * (CLK_KHZ / 1000); // short pulse in cycles
  localparam int PULSE_LONG_CYC = PULSE_LONG_US * (CLK_KHZ / 1000); // long pulse in cycles
  localparam int CNT_W = 23; // pulse counter width, holds the long count
endpackage

// ---- rtl/wks_pulse_timer.sv ----
`timescale 1ns/100ps
// one-shot pulse timer, timed from the first start, immune to later starts
module wks_pulse_timer #(
  parameter int unsigned SHORT_CYC = wks_pkg::PULSE_SHORT_CYC,
  parameter int unsigned LONG_CYC = wks_pkg::PULSE_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i, // wake event while pulse style is active
  input wire logic long_i, // duration select sampled at start
  output logic busy_o // high for exactly the pulse length
);
  // counter plus busy flag
  typedef struct packed {
    logic [wks_pkg::CNT_W-1:0] cnt;
    logic busy;
  } wks_tmr_s;

  wks_tmr_s st_reg;
  wks_tmr_s st_next;
  localparam logic [wks_pkg::CNT_W-1:0] SHORT_LD = wks_pkg::CNT_W'(SHORT_CYC - 1);
  localparam logic [wks_pkg::CNT_W-1:0] LONG_LD = wks_pkg::CNT_W'(LONG_CYC - 1);

  // load on an idle start, count down while busy
  always_comb begin
    st_next = st_reg;
    if (!st_reg.busy) begin
      if (start_i) begin
        st_next.busy = 1'b1;
        st_next.cnt = long_i ? LONG_LD : SHORT_LD;
      end
    end else if (st_reg.cnt == '0) begin
      st_next.busy = 1'b0;
    end else begin
      // further starts are ignored here
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_o = st_reg.busy;

  // a short pulse loads the short count
  short_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !st_reg.busy && !long_i) |=> (st_reg.busy && st_reg.cnt == SHORT_LD))
    else $error("short pulse length not loaded");
  // a long pulse loads the long count
  long_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !st_reg.busy && long_i) |=> (st_reg.busy && st_reg.cnt == LONG_LD))
    else $error("long pulse length not loaded");
  // a start during a pulse neither restarts nor extends it
  no_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && st_reg.busy && st_reg.cnt != '0) |=> (st_reg.cnt == $past(st_reg.cnt) - 1'b1))
    else $error("pulse restarted by later wake event");
endmodule

// ---- rtl/wks_top.sv ----
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
module wks_top #(
  parameter int unsigned SHORT_CYC = wks_pkg::PULSE_SHORT_CYC, // short pulse cycles
  parameter int unsigned LONG_CYC = wks_pkg::PULSE_LONG_CYC // long pulse cycles
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // nonvolatile memory loader, same clock
  input wire logic cfg_load_i, // strobe: configuration byte valid
  input wire logic [7:0] cfg_byte_i,
  input wire logic wff_load_start_i, // strobe: wake filter block begins
  input wire logic wff_byte_valid_i, // strobe: next wake filter block byte
  input wire logic [7:0] wff_byte_i,
  // wake sources
  input wire logic wake_pin_i, // external pin, asynchronous
  input wire logic packet_det_i,
  input wire logic wake_frame_filter_match_i,
  input wire logic exact_dest_addr_match_i,
  input wire logic phy_link_change_i,
  // wake request pin, two signals
  output logic wake_request_pin_o,
  output logic wake_request_pin_oe_n_o, // low while the pin is driven
  // loaded filter contents for the matcher
  output logic [31:0] wake_filter_config_reg_o,
  output logic [127:0] wake_filter_byte_mask_reg_o,
  output logic irq_o // high while an enabled status bit is set
);
  // whole module state
  typedef struct packed {
    logic [7:0] cfg; // wake_signal_config_byte
    logic [31:0] fcfg; // wake_filter_config_reg
    logic [127:0] mask; // wake_filter_byte_mask_reg, four words
    logic [4:0] ldcnt; // bytes of wake filter block taken
    logic [wks_pkg::ST_W-1:0] status; // sticky events
    logic [wks_pkg::ST_W-1:0] ien; // interrupt enables
    logic ack; // bus answer
    logic [31:0] dat; // bus read data
    logic pin; // wake request pin level
    logic oe_n; // wake request pin enable, low drives
    logic irq; // interrupt output
    logic sync1; // wake input pin first stage
    logic sync2; // wake input pin second stage
  } wks_state_s;

  wks_state_s st_reg;
  wks_state_s st_next;

  logic [wks_pkg::ST_W-1:0] raw_ev; // raw events this cycle
  logic [4:0] src_en; // which sources may wake
  logic evt_any; // any enabled event this cycle
  logic pend_any; // any enabled event still pending
  logic sig_en; // signalling enabled
  logic pulse_busy; // pulse timer running
  logic pin_active; // pin wants its active state
  logic bus_req; // new bus request this cycle
  logic [wks_pkg::ST_W-1:0] clr_bits; // clear strobes from a bus write

  // true when the bus address hits one word
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // read data mux for the register map
  function automatic logic [31:0] rd_mux(input wks_state_s s, input logic [7:0] adr);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (hit(adr, wks_pkg::OFS_CFG)) begin
      r = {24'h00_0000, s.cfg};
    end else if (hit(adr, wks_pkg::OFS_FCFG)) begin
      r = s.fcfg;
    end else if (adr[7:2] >= wks_pkg::OFS_MASK0[7:2] && adr[7:2] <= wks_pkg::OFS_MASK3[7:2]) begin
      r = s.mask[32*(adr[4:2] - wks_pkg::OFS_MASK0[4:2]) +: 32];
    end else if (hit(adr, wks_pkg::OFS_STAT)) begin
      r = {26'h000_0000, s.status};
    end else if (hit(adr, wks_pkg::OFS_IEN)) begin
      r = {26'h000_0000, s.ien};
    end
    rd_mux = r;
  endfunction

  // pulse one-shot
  wks_pulse_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_pulse (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(sig_en && st_reg.cfg[wks_pkg::BIT_STYLE] && evt_any),
    .long_i(st_reg.cfg[wks_pkg::BIT_DUR]),
    .busy_o(pulse_busy)
  );

  // source gating and pin decision
  always_comb begin
    sig_en = st_reg.cfg[wks_pkg::BIT_SIG_EN];
    raw_ev = '0;
    raw_ev[wks_pkg::ST_PIN] = st_reg.sync2;
    raw_ev[wks_pkg::ST_PKT] = packet_det_i;
    raw_ev[wks_pkg::ST_WFF] = wake_frame_filter_match_i;
    raw_ev[wks_pkg::ST_DA] = exact_dest_addr_match_i;
    raw_ev[wks_pkg::ST_LINK] = phy_link_change_i;
    // the wake pin and filter match have no enable of their own here
    src_en = 5'h1f;
    src_en[wks_pkg::ST_LINK] = st_reg.cfg[wks_pkg::BIT_LINK_EN];
    src_en[wks_pkg::ST_PKT] = st_reg.cfg[wks_pkg::BIT_PKT_EN];
    src_en[wks_pkg::ST_DA] = st_reg.cfg[wks_pkg::BIT_DA_EN];
    evt_any = sig_en && |(raw_ev[4:0] & src_en);
    pend_any = sig_en && |(st_reg.status[4:0] & src_en);
    // level style follows pending status, pulse style the timer
    if (st_reg.cfg[wks_pkg::BIT_STYLE]) begin
      pin_active = pulse_busy;
    end else begin
      pin_active = pend_any;
    end
  end

  // bus request and clear strobes
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
    clr_bits = '0;
    if (bus_req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, wks_pkg::OFS_CLR)) begin
      clr_bits = wb_dat_i[wks_pkg::ST_W-1:0];
    end
  end

  // next state
  always_comb begin
    st_next = st_reg;
    // two-flop synchroniser for the wake input pin
    st_next.sync1 = wake_pin_i;
    st_next.sync2 = st_reg.sync1;

    // configuration byte from the loader
    if (cfg_load_i) begin
      st_next.cfg = cfg_byte_i;
    end

    // wake filter block: config word first, then the byte masks
    if (wff_load_start_i) begin
      st_next.ldcnt = '0;
    end else if (wff_byte_valid_i && st_reg.ldcnt < 5'(wks_pkg::WFF_LEN)) begin
      // bytes past the documented length are dropped
      if (st_reg.ldcnt < 5'(wks_pkg::WFF_CFG_BYTES)) begin
        st_next.fcfg[8*st_reg.ldcnt[1:0] +: 8] = wff_byte_i;
      end else begin
        // full count keeps mask bytes 12..15 from wrapping below zero
        st_next.mask[8*(st_reg.ldcnt - 5'(wks_pkg::WFF_CFG_BYTES)) +: 8] = wff_byte_i;
      end
      st_next.ldcnt = st_reg.ldcnt + 5'h01;
    end

    // sticky status: clear first, then set so an event is never lost
    st_next.status = st_reg.status & ~clr_bits;
    st_next.status[4:0] = st_next.status[4:0] | raw_ev[4:0];
    if (wff_byte_valid_i && !wff_load_start_i && st_reg.ldcnt == 5'(wks_pkg::WFF_LEN - 1)) begin
      st_next.status[wks_pkg::ST_LOADED] = 1'b1;
    end

    // bus slave: answer one cycle after the request, drop after one
    st_next.ack = bus_req;
    st_next.dat = 32'h0000_0000;
    if (bus_req) begin
      if (!wb_we_i) begin
        st_next.dat = rd_mux(st_reg, wb_adr_i);
      end else if (wb_sel_i[0] && hit(wb_adr_i, wks_pkg::OFS_IEN)) begin
        st_next.ien = wb_dat_i[wks_pkg::ST_W-1:0];
      end
    end

    // interrupt level
    st_next.irq = |(st_reg.status & st_reg.ien);

    // wake request pin drive
    if (!sig_en) begin
      // nothing else in the byte matters when signalling is off
      st_next.pin = 1'b0;
      st_next.oe_n = 1'b1;
    end else begin
      // active level is the polarity bit, inactive its inverse
      st_next.pin = pin_active ? st_reg.cfg[wks_pkg::BIT_POL] : ~st_reg.cfg[wks_pkg::BIT_POL];
      if (st_reg.cfg[wks_pkg::BIT_DRV]) begin
        st_next.oe_n = 1'b0;
      end else begin
        // open-drain drives only the active state
        st_next.oe_n = ~pin_active;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.cfg <= wks_pkg::CFG_RST;
      st_reg.ien <= wks_pkg::IEN_RST;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign wake_request_pin_o = st_reg.pin;
  assign wake_request_pin_oe_n_o = st_reg.oe_n;
  assign wake_filter_config_reg_o = st_reg.fcfg;
  assign wake_filter_byte_mask_reg_o = st_reg.mask;
  assign irq_o = st_reg.irq;

  // pin never driven while signalling is off
  disabled_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_reg.cfg[wks_pkg::BIT_SIG_EN] |=> wake_request_pin_oe_n_o)
    else $error("wake pin driven while signalling disabled");
  // pulse style drives the active polarity while the timer runs
  pulse_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sig_en && st_reg.cfg[wks_pkg::BIT_STYLE] && pulse_busy)
      |=> (wake_request_pin_o == $past(st_reg.cfg[wks_pkg::BIT_POL])))
    else $error("pulse not shown on wake pin");
  // level style holds the active state while status is pending
  level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sig_en && !st_reg.cfg[wks_pkg::BIT_STYLE] && pend_any)
      |=> (wake_request_pin_o == $past(st_reg.cfg[wks_pkg::BIT_POL]) && !wake_request_pin_oe_n_o))
    else $error("level wake not held");
  // push-pull keeps driving both states
  push_pull_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sig_en && st_reg.cfg[wks_pkg::BIT_DRV]) |=> !wake_request_pin_oe_n_o)
    else $error("push-pull pin released");
  // open-drain only ever drives the active level
  open_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sig_en && !st_reg.cfg[wks_pkg::BIT_DRV] && !pin_active) |=> wake_request_pin_oe_n_o)
    else $error("open-drain pin drives inactive level");
  // disabled link change alone cannot wake
  link_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_reg.cfg[wks_pkg::BIT_LINK_EN] && raw_ev[4:0] == 5'h10) |-> !evt_any)
    else $error("link change woke while disabled");
  // disabled packet detection alone cannot wake
  packet_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_reg.cfg[wks_pkg::BIT_PKT_EN] && raw_ev[4:0] == 5'h02) |-> !evt_any)
    else $error("packet woke while disabled");
  // disabled address match alone cannot wake
  addr_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_reg.cfg[wks_pkg::BIT_DA_EN] && raw_ev[4:0] == 5'h08) |-> !evt_any)
    else $error("address match woke while disabled");
  // filter match always wakes when signalling is on
  source_or_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sig_en && wake_frame_filter_match_i) |-> evt_any)
    else $error("filter match did not wake");
  // fifth block byte lands in the first mask byte and the count steps to 5
  load_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wff_byte_valid_i && !wff_load_start_i && st_reg.ldcnt == 5'h04)
      |=> (st_reg.mask[7:0] == $past(wff_byte_i) && st_reg.ldcnt == 5'h05))
    else $error("mask byte misplaced");
  // an event in the clear cycle still sets its status bit
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (packet_det_i && clr_bits[wks_pkg::ST_PKT]) |=> st_reg.status[wks_pkg::ST_PKT])
    else $error("event lost against clear");
endmodule

// ---- verif/wks_host_pm.sv ----
`timescale 1ns/100ps
// host power management input: resolves the wake wire and times active stretches
module wks_host_pm (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_o_i, // value the block puts on the wake wire
  input wire logic oe_n_i, // low while the block drives the wire
  input wire logic pol_i, // active level the host expects
  output logic wire_o, // level seen on the wire
  output int last_len_o, // length of the last driven active stretch
  output int n_pulse_o // number of active stretches seen
);
  int run; // cycles of the current active stretch
  // pull-up holds the wire high whenever nobody drives it
  assign wire_o = oe_n_i ? 1'b1 : pin_o_i;
  // count only driven active cycles so a released wire never looks active
  always @(posedge clk_i) begin
    if (rst_i) begin
      run <= 0;
      last_len_o <= 0;
      n_pulse_o <= 0;
    end else if (!oe_n_i && pin_o_i === pol_i) begin
      run <= run + 1;
    end else begin
      if (run > 0) begin
        last_len_o <= run;
        n_pulse_o <= n_pulse_o + 1;
      end
      run <= 0;
    end
  end
endmodule

// ---- verif/wks_top_bench.sv ----
`timescale 1ns/100ps
// self-checking bench for the wake signalling block
module wks_top_bench;
  localparam int SC = 5; // shortened short pulse
  localparam int LC = 20; // shortened long pulse
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ld = 1'b0, ws = 1'b0, wv = 1'b0;
  logic [7:0] adr = 8'h00, cfg_b = 8'h00, wf_b = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, fcfg, q;
  logic [127:0] fmask;
  logic [4:0] src = 5'h00; // pin, packet, filter, address, link
  logic pin, oe_n, irq, wire_lvl;
  int last_len, n_pulse;
  int n_mismatch = 0, cmp_count = 0, seed = 75, cyc_n = 0;

  wks_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_wks_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cfg_load_i(ld), .cfg_byte_i(cfg_b),
    .wff_load_start_i(ws), .wff_byte_valid_i(wv), .wff_byte_i(wf_b), .wake_pin_i(src[0]),
    .packet_det_i(src[1]), .wake_frame_filter_match_i(src[2]),
    .exact_dest_addr_match_i(src[3]), .phy_link_change_i(src[4]),
    .wake_request_pin_o(pin), .wake_request_pin_oe_n_o(oe_n),
    .wake_filter_config_reg_o(fcfg), .wake_filter_byte_mask_reg_o(fmask), .irq_o(irq));

  wks_host_pm u_wks_host_pm (.clk_i(clk_i), .rst_i(rst_i), .pin_o_i(pin), .oe_n_i(oe_n),
    .pol_i(cfg_b[4]), .wire_o(wire_lvl), .last_len_o(last_len), .n_pulse_o(n_pulse));

  // free-running clock, 20 ns period
  always #10 clk_i = ~clk_i;

  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // one comparison, counted
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // classic wishbone single cycle, waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    if (n >= 50) begin
      n_mismatch++;
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // one-cycle event on source s
  task automatic ev(input int s);
    @(posedge clk_i);
    src <= 5'h01 << s;
    @(posedge clk_i);
    src <= 5'h00;
  endtask

  // load the configuration byte and check it reads back, bus writes ignored
  task automatic load_cfg(input logic [7:0] c);
    @(posedge clk_i);
    ld <= 1'b1;
    cfg_b <= c;
    @(posedge clk_i);
    ld <= 1'b0;
    wb(1'b1, wks_pkg::OFS_CFG, {24'h0, ~c}, q);
    wb(1'b0, wks_pkg::OFS_CFG, 32'h0, q);
    chk("cfg", {24'h0, c}, q);
  endtask

  // filter block: start, 20 bytes plus one extra that must be dropped
  task automatic load_wff();
    logic [7:0] b[$];
    logic [31:0] e;
    @(posedge clk_i);
    ws <= 1'b1;
    @(posedge clk_i);
    ws <= 1'b0;
    for (int i = 0; i < 21; i++) begin
      e = $random(seed);
      wv <= 1'b1;
      wf_b <= e[7:0];
      b.push_back(e[7:0]);
      @(posedge clk_i);
    end
    wv <= 1'b0;
    @(posedge clk_i);
    chk("fcfg", {b[3], b[2], b[1], b[0]}, fcfg);
    for (int k = 0; k < 4; k++) begin
      e = {b[4*k+7], b[4*k+6], b[4*k+5], b[4*k+4]};
      chk("mask", e, fmask[32*k+:32]);
      wb(1'b0, wks_pkg::OFS_MASK0 + 8'(4 * k), 32'h0, q);
      chk("mask rd", e, q);
    end
    wb(1'b0, wks_pkg::OFS_STAT, 32'h0, q);
    chk("loaded", 32'h1, {31'h0, q[5]});
  endtask

  // counts and verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [7:0] c;
    logic [31:0] r;
    logic [5:0] ien;
    int s;
    logic en;
    logic act;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped place
    wb(1'b0, wks_pkg::OFS_CFG, 32'h0, q);
    chk("cfg rst", 32'h0, q);
    wb(1'b0, wks_pkg::OFS_IEN, 32'h0, q);
    chk("ien rst", 32'h0, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    load_wff();
    $display("test filter load done");
    // level style with random enables, polarity, driver and sources
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      c = {r[7], 2'b00, r[4:0]};
      s = int'(r[10:8]) % 5;
      ien = {1'b0, r[20:16]};
      load_cfg(c);
      wb(1'b1, wks_pkg::OFS_IEN, {26'h0, ien}, q);
      en = (s == 0) || (s == 2) || (s == 1 && c[1]) || (s == 3 && c[0]) || (s == 4 && c[2]);
      act = c[7] && en;
      ev(s);
      repeat (5) @(posedge clk_i);
      chk("oe_n", {31'h0, !act && !(c[7] && c[3])}, {31'h0, oe_n});
      chk("wire", {31'h0, act ? c[4] : (c[7] && c[3] ? !c[4] : 1'b1)}, {31'h0, wire_lvl});
      wb(1'b0, wks_pkg::OFS_STAT, 32'h0, q);
      chk("status", 32'h1 << s, q & 32'h1f);
      chk("irq", {31'h0, |((6'h01 << s) & ien)}, {31'h0, irq});
      wb(1'b1, wks_pkg::OFS_CLR, 32'h1f, q);
      repeat (3) @(posedge clk_i);
      chk("released", {31'h0, c[7] && c[3] ? !c[4] : 1'b1}, {31'h0, wire_lvl});
      chk("irq clr", 32'h0, {31'h0, irq});
    end
    $display("test level done");
    // pulse style: second event inside the pulse must not stretch it
    for (int d = 0; d < 2; d++) begin
      r = $random(seed);
      c = {2'b11, d[0], r[4:3], 3'b010};
      load_cfg(c);
      s = n_pulse;
      ev(1);
      ev(1);
      repeat (LC + 10) @(posedge clk_i);
      chk("pulse len", d ? LC : SC, last_len);
      chk("pulses", s + 1, n_pulse);
      wb(1'b1, wks_pkg::OFS_CLR, 32'h1f, q);
    end
    $display("test pulse done");
    report_and_stop();
  end
endmodule
